//--- gsc_pkg.sv
/*
 * gsc_pkg: constants for the global system control register bank.
 * Assumes a 32-bit peripheral bus whose byte offsets are word aligned.
 */
package gsc_pkg;
	localparam int unsigned GSC_AW = 8;
	// register byte offsets
	localparam logic [7:0] GSC_OFS_MEM_CLK = 8'h28;
	localparam logic [7:0] GSC_OFS_ZERO = 8'h2C;
	localparam logic [7:0] GSC_OFS_SYS_STAT = 8'h40;
	localparam logic [7:0] GSC_OFS_RST_ONE = 8'h44;
	localparam logic [7:0] GSC_OFS_CLK_GATE = 8'h48;
	localparam logic [7:0] GSC_OFS_EVT_EN = 8'h4C;
	localparam logic [7:0] GSC_OFS_REV = 8'h50;
	localparam logic [7:0] GSC_OFS_SYS_IE = 8'h54;
	// field positions
	localparam int unsigned GSC_RAM_ZERO_LIGHT_SLEEP_BIT = 8;
	localparam int unsigned GSC_FWS_LSB = 0;
	localparam int unsigned GSC_FWS_W = 3;
	localparam int unsigned GSC_RSVD_MSB = 7;
	localparam int unsigned GSC_RSVD_LSB = 3;
	localparam int unsigned GSC_ICACHE_ZERO_BIT = 1;
	localparam int unsigned GSC_SRAM_ZERO_BIT = 0;
	localparam int unsigned GSC_DBG_LOCK_BIT = 0;
	localparam int unsigned GSC_I2C_RST_BIT = 0;
	localparam int unsigned GSC_ICC_GATE_BIT = 11;
	localparam int unsigned GSC_FLC_GATE_BIT = 3;
	localparam int unsigned GSC_RX_EVT_BIT = 1;
	localparam int unsigned GSC_DMA_EVT_BIT = 0;
	localparam int unsigned GSC_REV_W = 16;
	localparam int unsigned GSC_UNLOCK_IE_BIT = 0;
	// reset values
	localparam logic [2:0] GSC_FWS_RESET = 3'h5;
	localparam logic [2:0] GSC_FWS_RESERVED = 3'h0;
	localparam logic [31:0] GSC_ZERO_WORD = 32'h0;
	// state of each self-clearing operation
	typedef enum logic [1:0] {
		GSC_OP_IDLE = 2'b00,
		GSC_OP_START = 2'b01,
		GSC_OP_WAIT = 2'b11
	} gsc_op_type;
endpackage : gsc_pkg

//--- gsc_regs.sv
/*
 * gsc_regs: global system control register bank with self-clearing
 * zeroization and peripheral reset, clock gates, wake events and status.
 * Assumes a simple same-clock register port (sel, wr, addr, wdata) answering
 * reads in the next cycle, and memory/peripheral targets with done handshakes.
 */
`timescale 1ns/100ps
// How it works
// - bit 8 puts RAM 0 in light sleep: contents kept, reads blocked.
// - a RAM-clearing reset clears RAM 0 even while light sleep is set.
// - bits 2:0 give flash wait states 1..7, 0 reserved, reset 5.
// - writing bit 1 zeroizes cache data and tag RAM, self-clears when done.
// - writing bit 0 zeroizes all data RAM, reads 0 when done.
// - status bit 0 shows factory debug lock; set means debug access blocked.
// - writing reset bit 0 resets second I2C, reads 0 when complete.
// - gate bit 11 stops cache controller bus clock; reset 0.
// - gate bit 3 stops flash controller clock, blocking flash fetches.
// - gating a peripheral clock keeps its register contents.
// - event bit 1 enables the wake event for wait-for-event sleep.
// - event bit 0 lets DMA count-to-zero completion raise the wake event.
// - revision bits 15:0 read two ASCII characters; upper bits reserved.
// - enable bit 0 raises power sequencer interrupt while debug unlocked.

// register map, byte offsets on the register port:
//   0x28 memory clock control: light sleep bit 8, reserved 7:3, flash wait states 2:0
//   0x2C memory zeroize control: cache zeroize bit 1, data ram zeroize bit 0
//   0x40 system status flags: debug lock bit 0, read only
//   0x44 peripheral reset one: second i2c reset bit 0, self-clearing
//   0x48 peripheral clock gate one: cache gate bit 11, flash gate bit 3
//   0x4C event wake enable: receive event bit 1, dma count-to-zero bit 0
//   0x50 chip revision: two ascii characters in 15:0, read only
//   0x54 system status irq enable: unlock interrupt enable bit 0
// limitations:
//   there are no byte enables; a write replaces the whole word, except that a zero wait-state field or a zero start bit is ignored
//   a self-clearing bit reads 1 until its target reports done, so a target
//   that never answers leaves the bit stuck; there is no timeout here
module gsc_regs #(
	parameter logic [15:0] REVISION_ID = 16'h5858 // arbitrary value
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reg_sel,
	input wire logic reg_wr,
	input wire logic [gsc_pkg::GSC_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic debug_lock_pin,
	input wire logic ram_reset_evt,
	input wire logic sram_zero_done,
	input wire logic icache_zero_done,
	input wire logic second_i2c_reset_done,
	input wire logic dma_block_done,
	input wire logic [15:0] dma_transfer_count,
	input wire logic rx_event_in,
	output logic ram_zero_light_sleep,
	output logic ram_zero_clear,
	output logic [2:0] flash_wait_states,
	output logic sram_zero_start,
	output logic icache_zero_start,
	output logic second_i2c_reset,
	output logic icc_clk_gate,
	output logic flc_clk_gate,
	output logic wake_event_signal,
	output logic power_sequencer_irq
);
	import gsc_pkg::*;

	logic ram_zero_light_sleep_q;
	logic [2:0] fws_q;
	logic [4:0] mem_rsvd_q;
	logic [31:0] clk_gate_q;
	logic rx_evt_en_q;
	logic dma_evt_en_q;
	logic unlock_ie_q;
	logic lock_meta_q;
	logic lock_q;
	logic rx_meta_q;
	logic rx_sync_q;
	logic ram_rst_meta_q;
	logic ram_rst_q;
	logic wake_q;
	logic irq_q;
	logic ram_clear_q;
	logic [31:0] rdata_q;
	logic [31:0] mem_word;
	logic [31:0] zero_word;
	logic [31:0] stat_word;
	logic [31:0] rst_word;
	logic [31:0] evt_word;
	logic [31:0] rev_word;
	logic [31:0] ie_word;
	logic wr_mem_clk;
	logic wr_zero;
	logic wr_rst_one;
	logic wr_gate;
	logic wr_evt;
	logic wr_ie;
	logic [2:0] op_done;
	logic [2:0] op_req;
	logic [2:0] op_busy;
	logic [2:0] op_start;

	// write strobes, decoded once; a write and a read never share a cycle,
	// since reg_wr picks one of them, so the read mux needs no priority
	// writes to the read-only offsets decode to nothing and are dropped
	// write strobes, decoded once
	assign wr_mem_clk = reg_sel && reg_wr && (reg_addr == GSC_OFS_MEM_CLK);
	assign wr_zero = reg_sel && reg_wr && (reg_addr == GSC_OFS_ZERO);
	assign wr_rst_one = reg_sel && reg_wr && (reg_addr == GSC_OFS_RST_ONE);
	assign wr_gate = reg_sel && reg_wr && (reg_addr == GSC_OFS_CLK_GATE);
	assign wr_evt = reg_sel && reg_wr && (reg_addr == GSC_OFS_EVT_EN);
	assign wr_ie = reg_sel && reg_wr && (reg_addr == GSC_OFS_SYS_IE);

	// operation 0 sram zero, 1 cache zero, 2 second i2c reset; only a 1 starts
	// a zero written to a start bit leaves the operation alone, so software
	// may write back what it read without starting anything by accident
	assign op_req[0] = wr_zero && reg_wdata[GSC_SRAM_ZERO_BIT];
	assign op_req[1] = wr_zero && reg_wdata[GSC_ICACHE_ZERO_BIT];
	assign op_req[2] = wr_rst_one && reg_wdata[GSC_I2C_RST_BIT];
	assign op_done[0] = sram_zero_done;
	assign op_done[1] = icache_zero_done;
	assign op_done[2] = second_i2c_reset_done;

	// memory clock control; reserved bits are plain storage so read-modify-write keeps them
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ram_zero_light_sleep_q <= 1'b0;
			fws_q <= GSC_FWS_RESET;
			mem_rsvd_q <= '0;
		end else if (wr_mem_clk) begin
			ram_zero_light_sleep_q <= reg_wdata[GSC_RAM_ZERO_LIGHT_SLEEP_BIT];
			mem_rsvd_q <= reg_wdata[GSC_RSVD_MSB:GSC_RSVD_LSB];
			// reserved zero is refused so flash never runs without a wait state
			if (reg_wdata[GSC_FWS_LSB +: GSC_FWS_W] != GSC_FWS_RESERVED) begin
				fws_q <= reg_wdata[GSC_FWS_LSB +: GSC_FWS_W];
			end
		end
	end

	// clock gate register; all bits stored, only 11 and 3 drive gates
	// the gates only stop clocks: nothing here resets the gated targets,
	// so their registers survive a gate and resume when it opens
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			clk_gate_q <= GSC_ZERO_WORD;
		end else if (wr_gate) begin
			clk_gate_q <= reg_wdata;
		end
	end

	// wake event and interrupt enables
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_evt_en_q <= 1'b0;
			dma_evt_en_q <= 1'b0;
			unlock_ie_q <= 1'b0;
		end else begin
			if (wr_evt) begin
				rx_evt_en_q <= reg_wdata[GSC_RX_EVT_BIT];
				dma_evt_en_q <= reg_wdata[GSC_DMA_EVT_BIT];
			end
			if (wr_ie) begin
				unlock_ie_q <= reg_wdata[GSC_UNLOCK_IE_BIT];
			end
		end
	end

	// debug lock pin: a factory level, two flops before anything reads it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lock_meta_q <= 1'b0;
			lock_q <= 1'b0;
		end else begin
			lock_meta_q <= debug_lock_pin;
			lock_q <= lock_meta_q;
		end
	end

	// receive event pin; costs three cycles of lag before a wake
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_meta_q <= 1'b0;
			rx_sync_q <= 1'b0;
		end else begin
			rx_meta_q <= rx_event_in;
			rx_sync_q <= rx_meta_q;
		end
	end

	// ram-clearing reset event; a glitch shorter than a cycle may be missed
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ram_rst_meta_q <= 1'b0;
			ram_rst_q <= 1'b0;
		end else begin
			ram_rst_meta_q <= ram_reset_evt;
			ram_rst_q <= ram_rst_meta_q;
		end
	end

	// self-clearing operations: start pulse, then busy until the target reports done
	// the handshake per operation:
	//   idle: a 1 written to the start bit moves to start
	//   start: one cycle, the start pulse is out; done is not looked at yet,
	//          so a done high only in this cycle cannot end this one early
	//   wait: the read-back bit stays 1 until done is seen, then idle
	// the start pulse has its own flop so the output needs no decode
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_op
			gsc_op_type st_q;
			logic start_q;
			// start pulse flop, high exactly while the state is start
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					start_q <= 1'b0;
				end else begin
					start_q <= (st_q == GSC_OP_IDLE) && op_req[gi];
				end
			end
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					st_q <= GSC_OP_IDLE;
				end else begin
					case (st_q)
						GSC_OP_IDLE: begin
							if (op_req[gi]) begin
								st_q <= GSC_OP_START;
							end
						end
						GSC_OP_START: begin
							st_q <= GSC_OP_WAIT;
						end
						// further writes are ignored here, so no restart or abort
						GSC_OP_WAIT: begin
							if (op_done[gi]) begin
								st_q <= GSC_OP_IDLE;
							end
						end
						default: begin
							st_q <= GSC_OP_IDLE;
						end
					endcase
				end
			end
			assign op_busy[gi] = (st_q != GSC_OP_IDLE);
			assign op_start[gi] = start_q;
		end
	endgenerate

	// wake event, one cycle after an enabled cause is seen
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wake_q <= 1'b0;
		end else begin
			// dma event only counts when the block finished with count at zero
			wake_q <= (rx_evt_en_q && rx_sync_q)
				|| (dma_evt_en_q && dma_block_done && (dma_transfer_count == '0));
		end
	end

	// unlock interrupt level; lags the lock pin by three cycles
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= unlock_ie_q && !lock_q;
		end
	end

	// ram clear; light sleep does not mask it, and zeroize also clears ram 0
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ram_clear_q <= 1'b0;
		end else begin
			ram_clear_q <= ram_rst_q || op_start[0];
		end
	end

	// read words assembled per register; unused bits stay 0
	always_comb begin
		mem_word = GSC_ZERO_WORD;
		zero_word = GSC_ZERO_WORD;
		stat_word = GSC_ZERO_WORD;
		rst_word = GSC_ZERO_WORD;
		evt_word = GSC_ZERO_WORD;
		rev_word = GSC_ZERO_WORD;
		ie_word = GSC_ZERO_WORD;
		mem_word[GSC_RAM_ZERO_LIGHT_SLEEP_BIT] = ram_zero_light_sleep_q;
		mem_word[GSC_RSVD_MSB:GSC_RSVD_LSB] = mem_rsvd_q;
		mem_word[GSC_FWS_LSB +: GSC_FWS_W] = fws_q;
		zero_word[GSC_SRAM_ZERO_BIT] = op_busy[0];
		zero_word[GSC_ICACHE_ZERO_BIT] = op_busy[1];
		stat_word[GSC_DBG_LOCK_BIT] = lock_q;
		rst_word[GSC_I2C_RST_BIT] = op_busy[2];
		evt_word[GSC_RX_EVT_BIT] = rx_evt_en_q;
		evt_word[GSC_DMA_EVT_BIT] = dma_evt_en_q;
		rev_word[GSC_REV_W-1:0] = REVISION_ID;
		ie_word[GSC_UNLOCK_IE_BIT] = unlock_ie_q;
	end

	// read mux, answered one cycle after the request; unmapped reads 0
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= GSC_ZERO_WORD;
		end else if (reg_sel && !reg_wr) begin
			case (reg_addr)
				GSC_OFS_MEM_CLK: rdata_q <= mem_word;
				GSC_OFS_ZERO: rdata_q <= zero_word;
				GSC_OFS_SYS_STAT: rdata_q <= stat_word;
				GSC_OFS_RST_ONE: rdata_q <= rst_word;
				GSC_OFS_CLK_GATE: rdata_q <= clk_gate_q;
				GSC_OFS_EVT_EN: rdata_q <= evt_word;
				GSC_OFS_REV: rdata_q <= rev_word;
				GSC_OFS_SYS_IE: rdata_q <= ie_word;
				default: begin
					rdata_q <= GSC_ZERO_WORD;
				end
			endcase
		end
	end

	// all outputs straight from flops; gates only stop clocks, never reset targets
	assign reg_rdata = rdata_q;
	assign ram_zero_light_sleep = ram_zero_light_sleep_q;
	assign ram_zero_clear = ram_clear_q;
	assign flash_wait_states = fws_q;
	assign sram_zero_start = op_start[0];
	assign icache_zero_start = op_start[1];
	assign second_i2c_reset = g_op[2].st_q[0]; // held from start until done
	assign icc_clk_gate = clk_gate_q[GSC_ICC_GATE_BIT];
	assign flc_clk_gate = clk_gate_q[GSC_FLC_GATE_BIT];
	assign wake_event_signal = wake_q;
	assign power_sequencer_irq = irq_q;
endmodule : gsc_regs

//--- gsc_regs_assertions.sv
/* gsc_regs_chk: port-level checks of the global system control bank.
   assumes one clock and an active-high asynchronous reset */
`timescale 1ns/100ps
module gsc_regs_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reg_sel,
	input wire logic reg_wr,
	input wire logic [gsc_pkg::GSC_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic ram_reset_evt,
	input wire logic ram_zero_light_sleep,
	input wire logic ram_zero_clear,
	input wire logic [2:0] flash_wait_states,
	input wire logic sram_zero_start,
	input wire logic second_i2c_reset,
	input wire logic icc_clk_gate,
	input wire logic flc_clk_gate
);
	// single domain, so clocking and reset are given once
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic wr_en;
	assign wr_en = reg_sel && reg_wr;
	a_fws_legal: assert property (flash_wait_states != 3'h0) else $error("wait states zero");
	a_sleep_write: assert property (wr_en && reg_addr == 8'h28 |=>
		ram_zero_light_sleep == $past(reg_wdata[8])) else $error("light sleep not written");
	a_fws_write: assert property (wr_en && reg_addr == 8'h28 && reg_wdata[2:0] != 3'h0 |=>
		flash_wait_states == $past(reg_wdata[2:0])) else $error("wait states not written");
	a_fws_hold: assert property (wr_en && reg_addr == 8'h28 && reg_wdata[2:0] == 3'h0 |=>
		$stable(flash_wait_states)) else $error("reserved wait states taken");
	a_gate_write: assert property (wr_en && reg_addr == 8'h48 |=>
		icc_clk_gate == $past(reg_wdata[11]) && flc_clk_gate == $past(reg_wdata[3])) else $error("gate wrong");
	a_zero_cause: assert property ($rose(sram_zero_start) |->
		$past(wr_en && reg_addr == 8'h2C && reg_wdata[0])) else $error("zeroize without write");
	a_zero_pulse: assert property (sram_zero_start |=> !sram_zero_start) else $error("start too long");
	a_i2c_cause: assert property ($rose(second_i2c_reset) |->
		$past(wr_en && reg_addr == 8'h44 && reg_wdata[0])) else $error("i2c reset without write");
	a_ram_clear: assert property (ram_reset_evt [*4] |-> ram_zero_clear) else $error("ram not cleared");
endmodule : gsc_regs_chk
bind gsc_regs gsc_regs_chk chk (.sys_clk, .rst, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .ram_reset_evt,
	.ram_zero_light_sleep, .ram_zero_clear, .flash_wait_states, .sram_zero_start, .second_i2c_reset,
	.icc_clk_gate, .flc_clk_gate);

//--- gsc_regs_tb.sv
/* gsc_regs_tb: self-checking bench for the register bank.
   assumes the registered read port and done inputs described for gsc_regs */
`timescale 1ns/100ps
module gsc_regs_tb;
	localparam logic [15:0] REV = 16'h3C3C; // arbitrary value
	logic sys_clk = 1'b0, rst = 1'b1, reg_sel = 1'b0, reg_wr = 1'b0, lock = 1'b1, ram_ev = 1'b0;
	logic s_done = 1'b0, c_done = 1'b0, i_done = 1'b0, dma_done = 1'b0, rx = 1'b0;
	logic [7:0] reg_addr = 8'h0;
	logic [15:0] cnt = 16'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'h84F5, m = 32'h5, w;
	logic sleep, clr, s_go, c_go, i2c, icc, flc, wake, irq;
	logic [2:0] fws;
	int miscompares = 0, cmp_count = 0;
	gsc_regs #(.REVISION_ID(REV)) dut (.sys_clk, .rst, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
		.debug_lock_pin(lock), .ram_reset_evt(ram_ev), .sram_zero_done(s_done), .icache_zero_done(c_done),
		.second_i2c_reset_done(i_done), .dma_block_done(dma_done), .dma_transfer_count(cnt), .rx_event_in(rx),
		.ram_zero_light_sleep(sleep), .ram_zero_clear(clr), .flash_wait_states(fws), .sram_zero_start(s_go),
		.icache_zero_start(c_go), .second_i2c_reset(i2c), .icc_clk_gate(icc), .flc_clk_gate(flc),
		.wake_event_signal(wake), .power_sequencer_irq(irq));
	// 25 MHz
	always #20 sys_clk = ~sys_clk;
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// a zero wait-state field is refused, so the old value survives
	function logic [31:0] mem_exp(logic [31:0] o, logic [31:0] d);
		return {23'h0, d[8:3], (d[2:0] == 3'h0) ? o[2:0] : d[2:0]};
	endfunction : mem_exp
	task wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : wrap_up
	task chk(string n, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task wr(logic [7:0] a, logic [31:0] d);
		@(posedge sys_clk);
		{reg_sel, reg_wr, reg_addr, reg_wdata} <= {2'b11, a, d};
		@(posedge sys_clk);
		reg_sel <= 1'b0;
		#1;
	endtask : wr
	// read data is registered at the taking edge
	task rc(string n, logic [7:0] a, logic [31:0] e);
		@(posedge sys_clk);
		{reg_sel, reg_wr, reg_addr} <= {2'b10, a};
		@(posedge sys_clk);
		reg_sel <= 1'b0;
		#1 chk(n, e, reg_rdata);
	endtask : rc
	// one cause, then a window long enough for the sync lag
	task ev(logic [31:0] en, logic r, logic [15:0] c, logic e);
		bit s;
		s = 0;
		wr(8'h4C, en);
		@(posedge sys_clk);
		{rx, dma_done, cnt} <= {r, !r, c};
		repeat (6) begin
			@(posedge sys_clk);
			dma_done <= 1'b0;
			#1 s |= (wake === 1'b1);
		end
		rx <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk("wake", {31'h0, e}, {31'h0, s});
	endtask : ev
	// watchdog, far beyond the expected run
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		wrap_up();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		rc("mem", 8'h28, 32'h5);
		for (int i = 0; i < 6; i++) rc("reset", 8'h2C + 8'(i * 4), 32'(i == 5));
		rc("rev", 8'h50, {16'h0, REV});
		wr(8'h50, 32'hFFFF);
		rc("rev", 8'h50, {16'h0, REV});
		rc("gate", 8'h48, 32'h0);
		rc("unmapped", 8'h58, 32'h0);
		for (int i = 0; i < 12; i++) begin
			w = (i == 0) ? 32'h108 : rnd();
			wr(8'h28, w);
			m = mem_exp(m, w);
			chk("mem pins", {23'h0, m[8], 5'h0, m[2:0]}, {23'h0, sleep, 5'h0, fws});
			rc("mem", 8'h28, m);
			w = rnd();
			wr(8'h48, w); // no code runs from flash here, so gating it is safe
			chk("gate pins", {30'h0, w[11], w[3]}, {30'h0, icc, flc});
			rc("gate", 8'h48, w);
		end
		for (int i = 0; i < 2; i++) begin
			wr(8'h2C, 32'h1 << i);
			chk("start", 32'h1 << i, {30'h0, c_go, s_go});
			rc("busy", 8'h2C, 32'h1 << i);
			wr(8'h2C, 32'h1 << i);
			chk("restart", 32'h0, {30'h0, c_go, s_go});
			wr(8'h2C, 32'h0);
			rc("busy", 8'h2C, 32'h1 << i);
			{c_done, s_done} <= 2'(1 << i);
			@(posedge sys_clk);
			{c_done, s_done} <= 2'b00;
			rc("done", 8'h2C, 32'h0);
		end
		wr(8'h44, 32'h1);
		chk("i2c", 32'h1, {31'h0, i2c});
		@(posedge sys_clk);
		i_done <= 1'b1;
		@(posedge sys_clk);
		i_done <= 1'b0;
		rc("rst1", 8'h44, 32'h0);
		ev(32'h2, 1'b1, 16'h0, 1'b1);
		ev(32'h1, 1'b1, 16'h0, 1'b0);
		ev(32'h1, 1'b0, 16'h0, 1'b1);
		ev(32'h1, 1'b0, 16'(rnd()) | 16'h1, 1'b0);
		ev(32'h2, 1'b0, 16'h0, 1'b0);
		wr(8'h40, 32'h0);
		rc("stat", 8'h40, 32'h1);
		wr(8'h54, 32'h1);
		rc("ie", 8'h54, 32'h1);
		chk("irq locked", 32'h0, {31'h0, irq});
		lock <= 1'b0;
		repeat (5) @(posedge sys_clk);
		#1 chk("irq", 32'h1, {31'h0, irq});
		wr(8'h54, 32'h0);
		@(posedge sys_clk);
		#1 chk("irq off", 32'h0, {31'h0, irq});
		wr(8'h28, 32'h1FC); // four wait states, reserved bits written back
		rc("mem", 8'h28, 32'h1FC);
		wr(8'h28, 32'h105);
		ram_ev <= 1'b1;
		repeat (6) @(posedge sys_clk);
		#1 chk("clear", 32'h1, {31'h0, clr});
		ram_ev <= 1'b0;
		repeat (4) @(posedge sys_clk);
		wrap_up();
	end
endmodule : gsc_regs_tb
